// *** core/bps_filter.sv ***
// synchroniser plus continuous-level duration counter
`timescale 1ns/1ps
module bps_filter (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        raw_in,
  input  wire logic [15:0] limit_in,
  output logic             sync_out,
  output logic             hit_out
);
  logic        meta;
  logic [15:0] count;
  // two-stage synchroniser, then count while the level holds
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
      count    <= 16'h0000;
      hit_out  <= 1'b0;
    end else begin
      meta     <= raw_in;
      sync_out <= meta;
      if (!sync_out) begin
        count   <= 16'h0000;
        hit_out <= 1'b0;
      end else if (count >= limit_in) begin
        hit_out <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule

// *** core/bps_seq.sv ***
// burst and protection sequencer top with ahb-lite register slave
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "bps_regs.svh"
// Overview of operation
// - in burst, feedback above exit level leaves burst and restores normal limit
// - three light-load options; lowest selection band disables burst
// - low option uses low burst current limit and entry level, common exit
// - high option is default, higher burst limit and entry level
// - start-up presets high option, pull-up off, selection current on
// - selection current flows from supply 4.44 V until turn-on
// - at turn-on feedback band is sampled once to pick the option
// - option then held; selection current off, pull-up back on
// - before turn-on, error input above 0.2 V picks non-isolated mode
// - isolated mode keeps error amplifier disconnected from feedback node
// - line over-voltage protection holds while line comparator is high
// - no switching in line protection; line re-checked every restart cycle
// - supply under 50 us or over 55 us continuously stops switching
// - supply below off restarts start-up; above on resumes with soft-start
// - over-load beyond blanking time enters odd-skip auto-restart
// - over-temperature enters non-switch protection until hysteresis flag clears
// - sense level low past blanking for three pulses enters short protection
// - each fault maps to non-switch, odd-skip or plain auto-restart
// - every protection exit goes through a fresh soft-start
// - burst entered only after feedback below entry level for blanking time
// - in burst, switch on above burst-on level, off at burst-off level
// - burst frequency output raised while in burst; ctrl bit0 frequency variant is not used
module bps_seq (
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        vcc_above_4v44_in,
  input  wire logic        vcc_on_in,
  input  wire logic        vcc_below_off_in,
  input  wire logic        vcc_above_ovp_in,
  input  wire logic        fb_above_bias1_in,
  input  wire logic        fb_above_bias2_in,
  input  wire logic        err_above_bias_in,
  input  wire logic        fb_above_exit_in,
  input  wire logic        fb_below_entry_low_in,
  input  wire logic        fb_below_entry_high_in,
  input  wire logic        fb_above_burst_on_in,
  input  wire logic        fb_below_burst_off_in,
  input  wire logic        fb_above_overload_in,
  input  wire logic        line_ovp_in,
  input  wire logic        overtemp_in,
  input  wire logic        cs_below_short_in,
  input  wire logic        gate_on_in,
  output logic             gate_enable_out,
  output logic             soft_start_out,
  output logic             burst_operation_out,
  output logic             burst_limit_low_out,
  output logic             burst_freq_out,
  output logic             sel_current_out,
  output logic             pullup_switch_out,
  output logic             err_amp_connect_out,
  output logic             non_isolated_out
);
  // ==========================================================
  // comparator synchronisers and blanking filters
  logic        s_vcc44, s_vccon, s_off, s_ovp, s_b1, s_b2, s_err, s_exit;
  logic        s_enl, s_enh, s_bon, s_boff, s_ol, s_line, s_ot, s_cs, s_gate;
  logic        h_off, h_ovp, h_ol, h_enl, h_enh, h_cs;
  logic [15:0] overload_blanking;
  logic [15:0] sense_short_blanking;
  logic [15:0] lim_off, lim_ovp;
  assign lim_off = 16'(`BPS_VCC_OFF_CYC);
  assign lim_ovp = 16'(`BPS_VCC_OVP_CYC);
  // plain synchronisers share the filter with a zero limit
  bps_filter u_vcc44 (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(vcc_above_4v44_in),
    .limit_in(16'h0000), .sync_out(s_vcc44), .hit_out());
  bps_filter u_vccon (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(vcc_on_in),
    .limit_in(16'h0000), .sync_out(s_vccon), .hit_out());
  bps_filter u_off (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(vcc_below_off_in),
    .limit_in(lim_off), .sync_out(s_off), .hit_out(h_off));
  bps_filter u_ovp (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(vcc_above_ovp_in),
    .limit_in(lim_ovp), .sync_out(s_ovp), .hit_out(h_ovp));
  bps_filter u_b1 (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_above_bias1_in),
    .limit_in(16'h0000), .sync_out(s_b1), .hit_out());
  bps_filter u_b2 (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_above_bias2_in),
    .limit_in(16'h0000), .sync_out(s_b2), .hit_out());
  bps_filter u_err (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(err_above_bias_in),
    .limit_in(16'h0000), .sync_out(s_err), .hit_out());
  bps_filter u_exit (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_above_exit_in),
    .limit_in(16'h0000), .sync_out(s_exit), .hit_out());
  bps_filter u_enl (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_below_entry_low_in),
    .limit_in(`BPS_BEB_CYC), .sync_out(s_enl), .hit_out(h_enl));
  bps_filter u_enh (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_below_entry_high_in),
    .limit_in(`BPS_BEB_CYC), .sync_out(s_enh), .hit_out(h_enh));
  bps_filter u_bon (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_above_burst_on_in),
    .limit_in(16'h0000), .sync_out(s_bon), .hit_out());
  bps_filter u_boff (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_below_burst_off_in),
    .limit_in(16'h0000), .sync_out(s_boff), .hit_out());
  bps_filter u_ol (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(fb_above_overload_in),
    .limit_in(overload_blanking), .sync_out(s_ol), .hit_out(h_ol));
  bps_filter u_line (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(line_ovp_in),
    .limit_in(16'h0000), .sync_out(s_line), .hit_out());
  bps_filter u_ot (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(overtemp_in),
    .limit_in(16'h0000), .sync_out(s_ot), .hit_out());
  bps_filter u_cs (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(cs_below_short_in & gate_on_in),
    .limit_in(sense_short_blanking), .sync_out(s_cs), .hit_out(h_cs));
  bps_filter u_gate (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .raw_in(gate_on_in),
    .limit_in(16'h0000), .sync_out(s_gate), .hit_out());

  // ==========================================================
  // register file state
  logic [31:0] ctrl;          // bit0 frequency variant 125k, bit1 force protection
  logic [31:0] blank;         // [15:0] overload, [31:16] sense short blanking
  logic [7:0]  cause;         // sticky protection causes
  logic        ap_valid, ap_write;
  logic [11:0] ap_addr;
  assign overload_blanking    = blank[15:0];
  assign sense_short_blanking = blank[31:16];

  // ==========================================================
  // sequencer state
  bps_pkg::bps_state_e state, next_state;
  bps_pkg::bps_opt_e   opt;
  bps_pkg::bps_mode_e  mode;
  logic                odd_phase;
  logic [1:0]          stg_count;
  logic                gate_prev;
  logic                burst_sw;

  // fault decode and mode map
  wire f_line  = s_line;
  wire f_ot    = s_ot;
  wire f_uv    = h_off;
  wire f_ov    = h_ovp;
  wire f_ol    = h_ol && (state == bps_pkg::BPS_ST_NORMAL);
  wire f_cs    = (stg_count == `BPS_STG_PULSES);
  wire f_force = ctrl[1];
  wire any_fault = f_line | f_ot | f_uv | f_ov | f_ol | f_cs | f_force;
  wire bps_pkg::bps_mode_e fault_mode =
    (f_line | f_ot) ? bps_pkg::BPS_MODE_NSW :
    (f_ov | f_ol | f_cs) ? bps_pkg::BPS_MODE_SKIP : bps_pkg::BPS_MODE_AR;
  wire entry_hit = (opt == bps_pkg::BPS_OPT_LOW) ? h_enl : h_enh;
  wire burst_ok  = (opt != bps_pkg::BPS_OPT_NONE);
  wire gate_fall = gate_prev && !s_gate;
  wire [7:0] cause_set = {1'b0, f_force, f_cs, f_ol, f_ot, f_ov, f_uv, f_line};

  // next state of the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      bps_pkg::BPS_ST_STARTUP: if (s_vccon) next_state = bps_pkg::BPS_ST_NORMAL;
      bps_pkg::BPS_ST_NORMAL: begin
        if (any_fault) next_state = bps_pkg::BPS_ST_PROT;
        else if (burst_ok && entry_hit) next_state = bps_pkg::BPS_ST_BURST;
      end
      bps_pkg::BPS_ST_BURST: begin
        if (any_fault) next_state = bps_pkg::BPS_ST_PROT;
        else if (s_exit) next_state = bps_pkg::BPS_ST_NORMAL;
      end
      bps_pkg::BPS_ST_PROT: if (s_off) next_state = bps_pkg::BPS_ST_WAIT;
      bps_pkg::BPS_ST_WAIT: begin
        // each supply restart cycle re-checks line and temperature
        if (s_vccon && !s_line && !s_ot && !(mode == bps_pkg::BPS_MODE_SKIP && !odd_phase))
          next_state = bps_pkg::BPS_ST_NORMAL;
        else if (s_vccon)
          next_state = bps_pkg::BPS_ST_PROT;
      end
      default: next_state = bps_pkg::BPS_ST_STARTUP;
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state     <= bps_pkg::BPS_ST_STARTUP;
      mode      <= bps_pkg::BPS_MODE_AR;
      odd_phase <= 1'b0;
    end else begin
      state <= next_state;
      if (state != bps_pkg::BPS_ST_PROT && next_state == bps_pkg::BPS_ST_PROT &&
          state != bps_pkg::BPS_ST_WAIT) begin
        mode      <= fault_mode;
        odd_phase <= 1'b0;
      end else if (state == bps_pkg::BPS_ST_WAIT && s_vccon) begin
        odd_phase <= ~odd_phase;
      end
    end
  end

  // option and isolation latch at supply turn-on
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      opt              <= bps_pkg::BPS_OPT_HIGH;
      non_isolated_out <= 1'b0;
    end else if (state == bps_pkg::BPS_ST_STARTUP && !s_vccon) begin
      non_isolated_out <= s_err;
    end else if (state == bps_pkg::BPS_ST_STARTUP && s_vccon && sel_current_out) begin
      opt <= s_b2 ? bps_pkg::BPS_OPT_HIGH :
             s_b1 ? bps_pkg::BPS_OPT_LOW : bps_pkg::BPS_OPT_NONE;
    end
  end

  // sense short pulse counter
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_prev <= 1'b0;
      stg_count <= 2'h0;
    end else begin
      gate_prev <= s_gate;
      if (state == bps_pkg::BPS_ST_PROT || state == bps_pkg::BPS_ST_WAIT) stg_count <= 2'h0;
      else if (gate_fall) stg_count <= h_cs ? stg_count + 2'h1 : 2'h0;
    end
  end

  // burst hysteresis switching
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      burst_sw <= 1'b0;
    end else if (state != bps_pkg::BPS_ST_BURST) begin
      burst_sw <= 1'b0;
    end else if (s_bon) begin
      burst_sw <= 1'b1;
    end else if (s_boff) begin
      burst_sw <= 1'b0;
    end
  end

  // registered outputs to the analog front end and gate driver
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gate_enable_out     <= 1'b0;
      soft_start_out      <= 1'b0;
      burst_operation_out <= 1'b0;
      burst_limit_low_out <= 1'b0;
      burst_freq_out      <= 1'b0;
      sel_current_out     <= 1'b0;
      pullup_switch_out   <= 1'b1;
      err_amp_connect_out <= 1'b0;
    end else begin
      gate_enable_out <= (next_state == bps_pkg::BPS_ST_NORMAL) ||
                         (next_state == bps_pkg::BPS_ST_BURST && burst_sw);
      soft_start_out  <= (state != bps_pkg::BPS_ST_NORMAL && state != bps_pkg::BPS_ST_BURST) &&
                         next_state == bps_pkg::BPS_ST_NORMAL;
      burst_operation_out <= (next_state == bps_pkg::BPS_ST_BURST);
      burst_limit_low_out <= (opt == bps_pkg::BPS_OPT_LOW);
      burst_freq_out      <= (next_state == bps_pkg::BPS_ST_BURST);
      sel_current_out     <= (state == bps_pkg::BPS_ST_STARTUP) && s_vcc44 && !s_vccon
                             && !sel_current_out ? 1'b1 :
                             (state == bps_pkg::BPS_ST_STARTUP) && !s_vccon && sel_current_out;
      pullup_switch_out   <= !((state == bps_pkg::BPS_ST_STARTUP) && !s_vccon);
      err_amp_connect_out <= non_isolated_out;
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  wire ahb_take = hsel_in && htrans_in[1] && hready_in;
  wire [31:0] rd_mux =
    (haddr_in == `BPS_A_CTRL)   ? ctrl :
    (haddr_in == `BPS_A_STATUS) ? {20'h00000, non_isolated_out, 2'(opt), 2'(mode), odd_phase,
                                   gate_enable_out, burst_operation_out, 1'b0, 3'(state)} :
    (haddr_in == `BPS_A_CAUSE)  ? {24'h000000, cause} :
    (haddr_in == `BPS_A_BLANK)  ? blank : 32'h0000_0000;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 12'h000;
    end else if (hready_in) begin
      ap_valid <= ahb_take;
      ap_write <= hwrite_in;
      ap_addr  <= haddr_in;
    end
  end
  // registers: cause is write-one-to-clear, a new cause wins
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl  <= `BPS_CTRL_RST;
      blank <= {`BPS_BLANK_RST, `BPS_BLANK_RST};
      cause <= 8'h00;
    end else begin
      if (ap_valid && ap_write && ap_addr == `BPS_A_CTRL) ctrl <= hwdata_in & 32'h0000_0003;
      if (ap_valid && ap_write && ap_addr == `BPS_A_BLANK) blank <= hwdata_in;
      if (ap_valid && ap_write && ap_addr == `BPS_A_CAUSE)
        cause <= (cause & ~hwdata_in[7:0]) | cause_set;
      else
        cause <= cause | cause_set;
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= (ahb_take && !hwrite_in) ? rd_mux : hrdata_out;
    end
  end
endmodule

// *** pkg/bps_pkg.sv ***
// types of the burst and protection sequencer
package bps_pkg;
  typedef enum logic [1:0] {
    BPS_OPT_NONE = 2'b00,
    BPS_OPT_LOW  = 2'b01,
    BPS_OPT_HIGH = 2'b10
  } bps_opt_e;
  typedef enum logic [2:0] {
    BPS_ST_STARTUP = 3'b000,
    BPS_ST_NORMAL  = 3'b001,
    BPS_ST_BURST   = 3'b010,
    BPS_ST_PROT    = 3'b011,
    BPS_ST_WAIT    = 3'b100
  } bps_state_e;
  typedef enum logic [1:0] {
    BPS_MODE_AR   = 2'b00,
    BPS_MODE_NSW  = 2'b01,
    BPS_MODE_SKIP = 2'b10
  } bps_mode_e;
endpackage

// *** pkg/bps_regs.svh ***
// register map, reset values and timing constants of the burst and protection sequencer
`ifndef BPS_REGS_SVH
`define BPS_REGS_SVH
`define BPS_A_CTRL      12'h000
`define BPS_A_STATUS    12'h004
`define BPS_A_CAUSE     12'h008
`define BPS_A_BLANK     12'h00C
`define BPS_CTRL_RST    32'h0000_0000
`define BPS_BLANK_RST   16'h0F00
`define BPS_VCC_OFF_US  50
`define BPS_VCC_OVP_US  55
`define BPS_CLK_MHZ     50
`define BPS_VCC_OFF_CYC (`BPS_VCC_OFF_US * `BPS_CLK_MHZ)
`define BPS_VCC_OVP_CYC (`BPS_VCC_OVP_US * `BPS_CLK_MHZ)
`define BPS_STG_PULSES  2'h3
`define BPS_BEB_CYC     16'h0100
`define BPS_CNT_W       16
`endif

// *** verif/bps_seq_checker.sv ***
// assertion checker of the burst and protection sequencer
`timescale 1ns/1ps
`include "bps_regs.svh"
module bps_seq_checker (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic vcc_below_off_in,
  input wire logic vcc_above_ovp_in,
  input wire logic fb_below_entry_low_in,
  input wire logic fb_below_entry_high_in,
  input wire logic fb_above_exit_in,
  input wire logic line_ovp_in,
  input wire logic overtemp_in,
  input wire logic gate_enable_out,
  input wire logic soft_start_out,
  input wire logic burst_operation_out,
  input wire logic sel_current_out,
  input wire logic pullup_switch_out,
  input wire logic err_amp_connect_out,
  input wire logic non_isolated_out
);
  localparam int UV_LIM  = `BPS_VCC_OFF_CYC + 8;
  localparam int OVP_LIM = `BPS_VCC_OVP_CYC + 8;
  logic [15:0] uv_cnt;
  logic [15:0] ovp_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // cycles of continuous supply fault, plus sync and register margin in the limits
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_cnt  <= 16'h0000;
      ovp_cnt <= 16'h0000;
    end else begin
      uv_cnt  <= vcc_below_off_in ? uv_cnt + 16'h0001 : 16'h0000;
      ovp_cnt <= vcc_above_ovp_in ? ovp_cnt + 16'h0001 : 16'h0000;
    end
  end
  AST_UV_OFF: assert property (int'(uv_cnt) >= UV_LIM |-> !gate_enable_out)
    else $error("gate enabled after long supply under-voltage");
  AST_OVP_OFF: assert property (int'(ovp_cnt) >= OVP_LIM |-> !gate_enable_out)
    else $error("gate enabled after long supply over-voltage");
  AST_LINE_OFF: assert property (line_ovp_in [*6] |-> !gate_enable_out)
    else $error("gate enabled during line over-voltage");
  AST_OT_OFF: assert property (overtemp_in [*6] |-> !gate_enable_out)
    else $error("gate enabled during over-temperature");
  AST_BURST_EXIT: assert property (fb_above_exit_in [*6] |-> !burst_operation_out)
    else $error("burst held with feedback above exit level");
  AST_BURST_ENTRY: assert property ($rose(burst_operation_out) |->
      $past(fb_below_entry_low_in, 3) || $past(fb_below_entry_high_in, 3))
    else $error("burst entered without low feedback");
  AST_SEL_PULL: assert property (sel_current_out |-> !pullup_switch_out)
    else $error("selection current and pull-up both on");
  AST_ISO_DISC: assert property (!non_isolated_out |-> !err_amp_connect_out)
    else $error("error amplifier connected in isolated mode");
  AST_SS_PULSE: assert property (soft_start_out |=> !soft_start_out)
    else $error("soft-start pulse longer than one cycle");
endmodule
bind bps_seq bps_seq_checker i_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .vcc_below_off_in(vcc_below_off_in), .vcc_above_ovp_in(vcc_above_ovp_in),
  .fb_below_entry_low_in(fb_below_entry_low_in), .fb_below_entry_high_in(fb_below_entry_high_in),
  .fb_above_exit_in(fb_above_exit_in), .line_ovp_in(line_ovp_in), .overtemp_in(overtemp_in),
  .gate_enable_out(gate_enable_out), .soft_start_out(soft_start_out), .burst_operation_out(burst_operation_out),
  .sel_current_out(sel_current_out), .pullup_switch_out(pullup_switch_out),
  .err_amp_connect_out(err_amp_connect_out), .non_isolated_out(non_isolated_out));

// *** verif/bps_stage.sv ***
// model of the gate driver and current-sense comparator facing the sequencer
`timescale 1ns/1ps
module bps_stage (
  input  wire logic mclk_in,
  input  wire logic gate_enable_in,
  input  wire logic short_in,
  output logic      gate_on_out,
  output logic      cs_below_short_out
);
  logic [5:0] phase;
  // switching period of 64 clocks while enabled, restarting from zero
  always_ff @(posedge mclk_in) begin
    phase <= gate_enable_in ? phase + 6'h01 : 6'h00;
  end
  // on-time is the first half of each period
  assign gate_on_out = gate_enable_in & (phase < 6'h20);
  // sense sits near zero while off, and a shorted pin keeps it low while on
  assign cs_below_short_out = ~gate_on_out | short_in;
endmodule

// *** verif/tb_bps_seq.sv ***
// self-checking bench of the burst and protection sequencer
`timescale 1ns/1ps
`include "bps_regs.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_bps_seq;
  // ========================================
  // stimulus and observed signals
  logic        mclk_in, arst_n_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out, seen;
  logic [11:0] haddr_in;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in, hrdata_out, rd;
  logic        vcc_above_4v44_in, vcc_on_in, vcc_below_off_in, vcc_above_ovp_in, fb_above_bias1_in;
  logic        fb_above_bias2_in, err_above_bias_in, fb_above_exit_in, fb_below_entry_low_in, short_cmd;
  logic        fb_below_entry_high_in, fb_above_burst_on_in, fb_below_burst_off_in, fb_above_overload_in;
  logic        line_ovp_in, overtemp_in, gate_on_in, cs_below_short_in, gate_enable_out, soft_start_out;
  logic        burst_operation_out, burst_limit_low_out, burst_freq_out, sel_current_out;
  logic        pullup_switch_out, err_amp_connect_out, non_isolated_out;
  int          n_mismatch, compares, cyc;
  // the one slave's ready is the bus ready
  assign hready_in = hreadyout_out;
  bps_seq i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .vcc_above_4v44_in(vcc_above_4v44_in), .vcc_on_in(vcc_on_in), .vcc_below_off_in(vcc_below_off_in),
    .vcc_above_ovp_in(vcc_above_ovp_in), .fb_above_bias1_in(fb_above_bias1_in),
    .fb_above_bias2_in(fb_above_bias2_in), .err_above_bias_in(err_above_bias_in),
    .fb_above_exit_in(fb_above_exit_in), .fb_below_entry_low_in(fb_below_entry_low_in),
    .fb_below_entry_high_in(fb_below_entry_high_in), .fb_above_burst_on_in(fb_above_burst_on_in),
    .fb_below_burst_off_in(fb_below_burst_off_in), .fb_above_overload_in(fb_above_overload_in),
    .line_ovp_in(line_ovp_in), .overtemp_in(overtemp_in), .cs_below_short_in(cs_below_short_in),
    .gate_on_in(gate_on_in), .gate_enable_out(gate_enable_out), .soft_start_out(soft_start_out),
    .burst_operation_out(burst_operation_out), .burst_limit_low_out(burst_limit_low_out),
    .burst_freq_out(burst_freq_out), .sel_current_out(sel_current_out),
    .pullup_switch_out(pullup_switch_out), .err_amp_connect_out(err_amp_connect_out),
    .non_isolated_out(non_isolated_out));
  bps_stage i_stage (.mclk_in(mclk_in), .gate_enable_in(gate_enable_out), .short_in(short_cmd),
    .gate_on_out(gate_on_in), .cs_below_short_out(cs_below_short_in));
  // ========================================
  // clock, hang limit and tasks
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  // cut a hung run short
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel_in <= 1'b1;
    haddr_in <= a;
    hwrite_in <= wr;
    htrans_in <= 2'h2;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= d;
    do @(posedge mclk_in); while (hready_in !== 1'b1);
    q = hrdata_out;
  endtask
  task automatic do_reset();
    arst_n_in <= 1'b0;
    {vcc_above_4v44_in, vcc_on_in, vcc_below_off_in, vcc_above_ovp_in, fb_above_bias1_in, fb_above_bias2_in,
     err_above_bias_in, fb_above_exit_in, fb_below_entry_low_in, fb_below_entry_high_in, fb_above_burst_on_in,
     fb_below_burst_off_in, fb_above_overload_in, line_ovp_in, overtemp_in, short_cmd} <= 16'h0000;
    step(12);
    arst_n_in <= 1'b1;
    step(1);
  endtask
  // charge the supply with the given bias bands, turn on, then disturb the bands
  task automatic power_up(input logic b1, input logic b2, input logic er);
    vcc_above_4v44_in <= 1'b1;
    fb_above_bias1_in <= b1;
    fb_above_bias2_in <= b2;
    err_above_bias_in <= er;
    step(8);
    `CHK("sel_current", 1'b1, sel_current_out)
    `CHK("pullup_off", 1'b0, pullup_switch_out)
    vcc_on_in <= 1'b1;
    step(8);
    `CHK("sel_current_off", 1'b0, sel_current_out)
    `CHK("pullup_back", 1'b1, pullup_switch_out)
    `CHK("non_isolated", er, non_isolated_out)
    `CHK("err_amp", er, err_amp_connect_out)
    `CHK("gate_enable", 1'b1, gate_enable_out)
    fb_above_bias1_in <= ~b1;
    fb_above_bias2_in <= ~b2;
    bus(1'b1, `BPS_A_BLANK, 32'h0008_0010, rd);
  endtask
  // supply drops below off and recharges; reports whether a soft-start was seen
  task automatic restart(output logic ss);
    vcc_on_in <= 1'b0;
    vcc_below_off_in <= 1'b1;
    step(20);
    vcc_below_off_in <= 1'b0;
    step(2);
    vcc_on_in <= 1'b1;
    ss = 1'b0;
    repeat (20) begin
      @(posedge mclk_in);
      if (soft_start_out === 1'b1) ss = 1'b1;
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ========================================
  // test sequence
  initial begin
    {arst_n_in, hsel_in, hwrite_in, haddr_in, htrans_in, hwdata_in} = '0;
    hsize_in = 3'h2;
    step(1);
    for (int o = 0; o < 3; o++) begin
      do_reset();
      `CHK("reset_pullup", 1'b1, pullup_switch_out)
      power_up(o > 0, o == 2, o[0]);
      fb_below_entry_low_in <= 1'b1;
      fb_below_entry_high_in <= 1'b1;
      step(200);
      `CHK("burst_early", 1'b0, burst_operation_out)
      step(100);
      `CHK("burst_entered", o > 0, burst_operation_out)
      if (o > 0) `CHK("burst_limit_low", o == 1, burst_limit_low_out)
      if (o > 0) `CHK("burst_freq", 1'b1, burst_freq_out)
      {fb_below_entry_low_in, fb_below_entry_high_in, fb_above_exit_in} <= 3'h1;
      step(6);
      `CHK("burst_left", 1'b0, burst_operation_out)
      `CHK("normal_freq", 1'b0, burst_freq_out)
      $display("option test %0d done", o);
    end
    for (int f = 0; f < 2; f++) begin
      do_reset();
      power_up(1'b1, 1'b1, 1'b0);
      line_ovp_in <= (f == 0);
      overtemp_in <= (f == 1);
      step(8);
      `CHK("fault_gate_off", 1'b0, gate_enable_out)
      restart(seen);
      `CHK("fault_recheck", 1'b0, gate_enable_out)
      {line_ovp_in, overtemp_in} <= 2'h0;
      restart(seen);
      `CHK("fault_softstart", 1'b1, seen)
      `CHK("fault_resume", 1'b1, gate_enable_out)
      $display("non-switch test %0d done", f);
    end
    for (int f = 0; f < 2; f++) begin
      do_reset();
      power_up(1'b1, 1'b1, 1'b0);
      if (f == 0) {vcc_below_off_in, vcc_on_in} <= 2'h2;
      else vcc_above_ovp_in <= 1'b1;
      step(2400 + 250 * f);
      `CHK("supply_blanked", 1'b1, gate_enable_out)
      step(200);
      `CHK("supply_gate_off", 1'b0, gate_enable_out)
      vcc_above_ovp_in <= 1'b0;
      restart(seen);
      `CHK("supply_restart", f == 0, seen)
      if (f == 1) restart(seen);
      `CHK("supply_resume", 1'b1, gate_enable_out)
      $display("supply test %0d done", f);
    end
    for (int f = 0; f < 2; f++) begin
      do_reset();
      power_up(1'b1, 1'b1, 1'b0);
      fb_above_overload_in <= (f == 0);
      step(8);
      fb_above_overload_in <= 1'b0;
      step(4);
      `CHK("short_excursion", 1'b1, gate_enable_out)
      fb_above_overload_in <= (f == 0);
      short_cmd <= (f == 1);
      step(260);
      `CHK("skip_gate_off", 1'b0, gate_enable_out)
      {fb_above_overload_in, short_cmd} <= 2'h0;
      restart(seen);
      `CHK("skip_first", 1'b0, gate_enable_out)
      restart(seen);
      `CHK("skip_second", 1'b1, gate_enable_out)
      $display("odd-skip test %0d done", f);
    end
    bus(1'b0, `BPS_A_BLANK, rd, rd);
    `CHK("blank_read", 32'h0008_0010, rd)
    bus(1'b0, 12'h010, rd, rd);
    `CHK("unmapped_read", 32'h0000_0000, rd)
    `CHK("bus_okay", 1'b0, hresp_out)
    bus(1'b1, `BPS_A_CTRL, 32'h0000_0002, rd);
    step(8);
    `CHK("forced_off", 1'b0, gate_enable_out)
    $display("bus test done");
    close_out();
  end
endmodule
